// file: src/sar_adc_regs.svh
// Operation
// - Successive approximation gives an 8-bit result, one bit per five steps, readable.
// - Step clock is the oscillator divided by 12 or by 6.
// - After reset the divide-by-12 step clock is used.
// - At 8 MHz a conversion takes about 70 us slow, 35 us fast.
// - Writing start one launches a conversion and clears the done flag.
// - Finishing a conversion sets the done flag; result is then valid.
// - One conversion per start write; no automatic restart.
// - Start during a running conversion abandons it and begins afresh.
// - Start bit is write-only and always reads zero.
// - Converter interrupt request rises when the done flag is set.
// - Interrupt request reaches the core only while interrupt enable is set.
// - Power-on zero switches the converter off; one powers it.
// - Converter stays running and powered in wait mode unless power-on cleared.
// - End-of-conversion interrupt can wake the processor from wait mode.
// - Reset aborts conversion, control becomes 40h, enable clear, done set.
// - Control bits: enable 7, done 6, start 5, power 4, clock 2.
// - Clock select set gives divide by 6; cleared gives divide by 12.
// - Result register is read-only, result in bits 7 to 0.
`ifndef SAR_ADC_REGS_SVH
`define SAR_ADC_REGS_SVH

`define ADC_ADDR_W        12
`define ADC_RESULT_IDX    12'h0D0
`define ADC_CTRL_IDX      12'h0D1
`define ADC_RESULT_ADDR   12'h340
`define ADC_CTRL_ADDR     12'h344

`define ADC_CTRL_RESET    8'h40
`define ADC_BIT_IRQ_EN    7
`define ADC_BIT_DONE      6
`define ADC_BIT_START     5
`define ADC_BIT_POWER     4
`define ADC_BIT_CLK_SEL   2

`define ADC_DIV_SLOW      12
`define ADC_DIV_FAST      6
`define ADC_REF_OSC_MHZ   8
`define ADC_CONV_SLOW_US  70
`define ADC_CONV_FAST_US  35
`define ADC_CONV_STEPS    ((`ADC_CONV_SLOW_US * `ADC_REF_OSC_MHZ) / `ADC_DIV_SLOW)
`define ADC_BIT_STEPS     5
`define ADC_SAMPLE_STEPS  (`ADC_CONV_STEPS - 8 * `ADC_BIT_STEPS)

`endif

// file: src/sar_adc_pkg.sv
package sar_adc_pkg;

  typedef enum logic [1:0] {
    SAR_IDLE,
    SAR_SAMPLE,
    SAR_BITS
  } sar_phase_t;

  typedef struct packed {
    logic irq_en;
    logic done;
    logic power_on;
    logic clk_sel;
  } ctrl_t;

  typedef struct packed {
    sar_phase_t  phase;
    logic [5:0]  step_cnt;
    logic [2:0]  bit_idx;
    logic [7:0]  code;
    logic [7:0]  result;
    logic        done;
    logic        busy;
  } engine_state_t;

  typedef struct packed {
    logic [3:0] count;
    logic       tick;
  } div_state_t;

  typedef struct packed {
    ctrl_t       ctrl;
    logic [7:0]  result;
    logic        start;
    logic        irq;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        comp_meta;
    logic        comp_sync;
  } top_state_t;

endpackage

// file: src/sar_if.sv
`timescale 1ns/100ps
interface sar_if;
  logic       start;
  logic       step_en;
  logic       comp;
  logic       done;
  logic       busy;
  logic [7:0] code;
  logic [7:0] result;

  modport engine (
    input  start,
    input  step_en,
    input  comp,
    output done,
    output busy,
    output code,
    output result
  );

  modport ctrl (
    output start,
    output step_en,
    output comp,
    input  done,
    input  busy,
    input  code,
    input  result
  );
endinterface

// file: src/step_divider.sv
`timescale 1ns/100ps
`include "sar_adc_regs.svh"
module step_divider
  import sar_adc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic enable,
  input  wire logic fast,
  // Step enable pulse
  output logic      tick
);

  localparam logic [3:0] LAST_SLOW = 4'(`ADC_DIV_SLOW - 1);
  localparam logic [3:0] LAST_FAST = 4'(`ADC_DIV_FAST - 1);

  div_state_t s;
  div_state_t next_s;
  logic [3:0] last;

  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    last = fast ? LAST_FAST : LAST_SLOW;
    if (!enable)
    begin
      next_s.count = 4'h0;
    end
    else if (s.count >= last)
    begin
      next_s.count = 4'h0;
      next_s.tick = 1'b1;
    end
    else
    begin
      next_s.count = s.count + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign tick = s.tick;

endmodule

// file: src/sar_engine.sv
`timescale 1ns/100ps
`include "sar_adc_regs.svh"
module sar_engine
  import sar_adc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Converter side
  sar_if.engine     sar
);

  localparam logic [5:0] SAMPLE_LAST = 6'(`ADC_SAMPLE_STEPS - 1);
  localparam logic [5:0] BIT_LAST    = 6'(`ADC_BIT_STEPS - 1);

  engine_state_t s;
  engine_state_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    if (sar.start)
    begin
      next_s.phase = SAR_SAMPLE;
      next_s.step_cnt = 6'h00;
      next_s.bit_idx = 3'h7;
      next_s.code = 8'h00;
      next_s.busy = 1'b1;
    end
    else if (sar.step_en)
    begin
      case (s.phase)
        SAR_IDLE:
        begin
          next_s.busy = 1'b0;
        end
        SAR_SAMPLE:
        begin
          if (s.step_cnt >= SAMPLE_LAST)
          begin
            next_s.phase = SAR_BITS;
            next_s.step_cnt = 6'h00;
            next_s.code = 8'h80;
          end
          else
            next_s.step_cnt = s.step_cnt + 6'h01;
        end
        SAR_BITS:
        begin
          if (s.step_cnt >= BIT_LAST)
          begin
            next_s.step_cnt = 6'h00;
            if (!sar.comp)
              next_s.code[s.bit_idx] = 1'b0;
            if (s.bit_idx == 3'h0)
            begin
              next_s.phase = SAR_IDLE;
              next_s.busy = 1'b0;
              next_s.done = 1'b1;
              next_s.result = {s.code[7:1], sar.comp};
            end
            else
            begin
              next_s.bit_idx = s.bit_idx - 3'h1;
              next_s.code[s.bit_idx - 3'h1] = 1'b1;
            end
          end
          else
            next_s.step_cnt = s.step_cnt + 6'h01;
        end
        default:
        begin
          next_s.phase = SAR_IDLE;
          next_s.busy = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign sar.done   = s.done;
  assign sar.busy   = s.busy;
  assign sar.code   = s.code;
  assign sar.result = s.result;

endmodule

// file: src/sar_adc_control.sv
`timescale 1ns/100ps
`include "sar_adc_regs.svh"
module sar_adc_control
  import sar_adc_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`ADC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Analog front end
  input  wire logic                   comp_in,
  output logic      [7:0]             dac_code,
  output logic                        converter_power,
  output logic                        conv_busy,
  // Core interrupt and wake
  output logic                        conv_irq
);

  top_state_t s;
  top_state_t next_s;
  sar_if      sar ();
  logic       step_tick;
  logic       access;
  logic       wr_ctrl;

  function automatic logic addr_hit(input logic [`ADC_ADDR_W-1:0] a);
    addr_hit = (a == `ADC_CTRL_ADDR) || (a == `ADC_RESULT_ADDR);
  endfunction

  function automatic logic [31:0] read_word(
    input logic [`ADC_ADDR_W-1:0] a,
    input ctrl_t                  c,
    input logic [7:0]             r
  );
    logic [7:0] b;
    b = 8'h00;
    if (a == `ADC_CTRL_ADDR)
    begin
      b[`ADC_BIT_IRQ_EN]  = c.irq_en;
      b[`ADC_BIT_DONE]    = c.done;
      b[`ADC_BIT_POWER]   = c.power_on;
      b[`ADC_BIT_CLK_SEL] = c.clk_sel;
    end
    else if (a == `ADC_RESULT_ADDR)
      b = r;
    read_word = {24'h000000, b};
  endfunction

  step_divider u_div (
    .clk    (clk),
    .rst    (rst),
    .enable (s.ctrl.power_on),
    .fast   (s.ctrl.clk_sel),
    .tick   (step_tick)
  );

  sar_engine u_engine (
    .clk (clk),
    .rst (rst),
    .sar (sar.engine)
  );

  assign sar.start   = s.start;
  assign sar.step_en = step_tick && s.ctrl.power_on;
  assign sar.comp    = s.comp_sync;

  assign access  = psel && penable;
  assign wr_ctrl = access && s.pready && pwrite
                   && (paddr == `ADC_CTRL_ADDR);

  always_comb
  begin
    next_s = s;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.start = 1'b0;
    next_s.comp_meta = comp_in;
    next_s.comp_sync = s.comp_meta;
    // One wait state, answer from registers
    if (access && !s.pready)
    begin
      next_s.pready = 1'b1;
      next_s.pslverr = !addr_hit(paddr);
      next_s.prdata = pwrite ? 32'h00000000
                             : read_word(paddr, s.ctrl, s.result);
    end
    // only a completed, unaborted conversion lands
    if (sar.done && !s.start)
    begin
      next_s.result = sar.result;
      next_s.ctrl.done = 1'b1;
    end
    if (wr_ctrl)
    begin
      next_s.ctrl.irq_en   = pwdata[`ADC_BIT_IRQ_EN];
      next_s.ctrl.power_on = pwdata[`ADC_BIT_POWER];
      next_s.ctrl.clk_sel  = pwdata[`ADC_BIT_CLK_SEL];
      if (pwdata[`ADC_BIT_START])
      begin
        next_s.start = 1'b1;
        next_s.ctrl.done = 1'b0;
      end
    end
    next_s.irq = next_s.ctrl.done && next_s.ctrl.irq_en;
  end

  // reset value 40h, divide by 12
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.ctrl.done <= 1'(`ADC_CTRL_RESET >> `ADC_BIT_DONE);
    end
    else
      s <= next_s;
  end

  assign prdata          = s.prdata;
  assign pready          = s.pready;
  assign pslverr         = s.pslverr;
  assign converter_power = s.ctrl.power_on;
  assign conv_irq        = s.irq;
  assign dac_code        = sar.code;
  assign conv_busy       = sar.busy;

endmodule

// file: bench/sar_adc_control_props.sv
`timescale 1ns/100ps
`include "sar_adc_regs.svh"
module sar_adc_control_props
(
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst,
  // APB
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`ADC_ADDR_W-1:0] paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // Converter
  input wire logic [7:0]             dac_code,
  input wire logic                   converter_power,
  input wire logic                   conv_busy,
  input wire logic                   conv_irq
);
  logic        wr_ctrl;
  logic [10:0] run_cnt;

  assign wr_ctrl = psel && penable && pready && pwrite
                   && paddr == `ADC_CTRL_ADDR;

  // Powered cycles of one busy stretch
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      run_cnt <= 11'h000;
    else if (!conv_busy)
      run_cnt <= 11'h000;
    else if (converter_power)
      run_cnt <= run_cnt + 11'h001;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_ready_wait;
    $rose(psel && penable) |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("no ready one cycle into access");

  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");

  property p_err_data;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err_data: assert property (p_err_data)
    else $error("error without ready or with data");

  property p_upper_zero;
    pready |-> prdata[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read bits set");

  property p_power;
    wr_ctrl |=> ##1 converter_power == $past(pwdata[4], 2);
  endproperty
  a_power: assert property (p_power)
    else $error("power does not follow write");

  property p_start;
    wr_ctrl && pwdata[5:4] == 2'h3 && converter_power |-> ##[1:2] conv_busy;
  endproperty
  a_start: assert property (p_start)
    else $error("start did not begin conversion");

  property p_irq_clear;
    wr_ctrl && pwdata[5] |-> ##[1:3] !conv_irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("request kept after start");

  property p_irq_idle;
    $rose(conv_irq) |-> !conv_busy;
  endproperty
  a_irq_idle: assert property (p_irq_idle)
    else $error("request while busy");

  property p_frozen;
    conv_busy && $past(conv_busy) && !converter_power
      && !$past(converter_power) |-> $stable(dac_code);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("trial code moved while off");

  property p_bound;
    conv_busy |-> run_cnt < 11'h4B0;
  endproperty
  a_bound: assert property (p_bound)
    else $error("conversion too long");

  c_start: cover property (wr_ctrl && pwdata[5] && conv_busy);
  c_irq: cover property ($rose(conv_irq));
  c_err: cover property (pslverr);
endmodule

bind sar_adc_control sar_adc_control_props i_props (.clk, .rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .dac_code, .converter_power, .conv_busy, .conv_irq);

// file: bench/sar_front_model.sv
`timescale 1ns/100ps
module sar_front_model
(
  // Clock
  input wire logic       clk,
  // Converter side
  input wire logic       powered,
  input wire logic [7:0] dac_code,
  input wire logic [7:0] vin,
  output logic           comp_out
);
  initial comp_out = 1'b0;

  always @(posedge clk)
    comp_out <= powered ? (vin >= dac_code) : !comp_out;
endmodule

// file: bench/sar_adc_control_tb_top.sv
`timescale 1ns/100ps
`include "sar_adc_regs.svh"
`define CHK(g, e) check((g) === (e))
module sar_adc_control_tb_top;
  logic                   clk, rst, psel, penable, pwrite, pready;
  logic                   pslverr, comp_in, err;
  logic                   converter_power, conv_busy, conv_irq;
  logic [`ADC_ADDR_W-1:0] paddr;
  logic [31:0]            pwdata, prdata, rd;
  logic [7:0]             dac_code, vin, v;
  int                     error_cnt, n_tests, n;

  sar_adc_control i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .comp_in, .dac_code,
    .converter_power, .conv_busy, .conv_irq);
  sar_front_model i_front (.clk, .powered(converter_power), .dac_code,
    .vin, .comp_out(comp_in));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task check(input bit ok);
    n_tests++;
    if (!ok)
    begin
      error_cnt++;
      $display("unexpected at %0t: value mismatch", $time);
    end
  endtask

  task results;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    `CHK(k < 50, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task rd8(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
    v = rd[7:0];
  endtask

  task wait_done;
    repeat (2) @(posedge clk);
    n = 2;
    while (conv_busy !== 1'b0 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  task t_reset;
    rd8(`ADC_CTRL_ADDR);
    `CHK(v, 8'h40);
    rd8(`ADC_RESULT_ADDR);
    `CHK(v, 8'h00);
    `CHK(converter_power, 1'b0);
  endtask

  task t_bus;
    apb(1'b0, 12'h348, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0});
    wr(`ADC_RESULT_ADDR, 8'h77);
    `CHK(err, 1'b0);
    rd8(`ADC_RESULT_ADDR);
    `CHK({err, v}, 9'h000);
  endtask

  task t_conv(input logic [7:0] x, input logic f, input logic ie);
    int d;
    d = f ? `ADC_DIV_FAST : `ADC_DIV_SLOW;
    vin <= x;
    wr(`ADC_CTRL_ADDR, {ie, 3'b001, 1'b0, f, 2'b00});
    wr(`ADC_CTRL_ADDR, {ie, 3'b011, 1'b0, f, 2'b00});
    wait_done;
    `CHK((n - `ADC_CONV_STEPS * d) inside {[-d:d]}, 1'b1);
    rd8(`ADC_RESULT_ADDR);
    `CHK(v, x);
    rd8(`ADC_CTRL_ADDR);
    `CHK(v, {ie, 3'b101, 1'b0, f, 2'b00});
    `CHK(conv_irq, ie);
    repeat (100) @(posedge clk);
    `CHK(conv_busy, 1'b0);
  endtask

  task t_restart;
    logic [7:0] old;
    rd8(`ADC_RESULT_ADDR);
    old = v;
    vin <= 8'h5A;
    wr(`ADC_CTRL_ADDR, 8'h30);
    rd8(`ADC_CTRL_ADDR);
    `CHK(v[6:5], 2'b00);
    repeat (200) @(posedge clk);
    rd8(`ADC_RESULT_ADDR);
    `CHK(v, old);
    vin <= 8'hC3;
    wr(`ADC_CTRL_ADDR, 8'h30);
    wait_done;
    rd8(`ADC_RESULT_ADDR);
    `CHK(v, 8'hC3);
  endtask

  task t_pause;
    logic [7:0] frozen;
    vin <= 8'h81;
    wr(`ADC_CTRL_ADDR, 8'h30);
    repeat (100) @(posedge clk);
    wr(`ADC_CTRL_ADDR, 8'h00);
    @(posedge clk);
    frozen = dac_code;
    repeat (300) @(posedge clk);
    `CHK({converter_power, conv_busy}, 2'b01);
    `CHK(dac_code, frozen);
    wr(`ADC_CTRL_ADDR, 8'h10);
    wait_done;
    rd8(`ADC_RESULT_ADDR);
    `CHK(v, 8'h81);
  endtask

  task t_abort;
    wr(`ADC_CTRL_ADDR, 8'hB4);
    repeat (50) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    `CHK({conv_busy, conv_irq}, 2'b00);
    t_reset;
  endtask

  initial
  begin
    #400000;
    error_cnt++;
    results;
  end

  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    vin = 8'h00;
    error_cnt = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_bus;
    t_conv(8'hA5, 1'b0, 1'b1);
    t_conv(8'h3C, 1'b1, 1'b0);
    t_restart;
    t_pause;
    t_abort;
    results;
  end
endmodule
